/* File: hw/hpm_pin_mux.sv */
// Purpose: Host pin muxing, strap mode capture, report interrupt and GPIO pins
// Assumes: Pin inputs are asynchronous; core and engine signals share sys_clk
// Notes:   Pins are split into input, output and output enable; address select is input only, the interrupt has only output and enable
`include "hpm_pin_mux_map.svh"
`default_nettype none

// Overview of operation
// RULE_01: Interrupt line is pulled low while any unread report is pending.
// RULE_02: Each host read consumes one report; line released when none remain.
// RULE_03: Host should sense the interrupt by level and service while low.
// RULE_04: Strap sampled at every reset; low picks I2C, high picks SPI.
// RULE_05: In SPI mode the strap pin becomes a driven MISO output.
// RULE_06: In SPI mode the shared data pin is the SCK input.
// RULE_07: In SPI mode the shared clock pin is the active-low select input.
// RULE_08: In SPI mode the address select pin is the MOSI input.
// RULE_09: In I2C mode the two shared pins are SDA and SCL.
// RULE_10: In I2C mode the address select level picks one of two addresses.
// RULE_11: Five general purpose pins, host configurable, each weakly pulled up.
// RULE_12: Configuration can make pin 1 horizontal sync and pin 2 external sync.
// RULE_13: Mode stays latched until the next reset, ignoring later strap changes.
module hpm_pin_mux
  import hpm_pkg::*;
#(
  parameter int CNT_W  = 8,
  parameter int GPIO_N = `HPM_GPIO_COUNT
) (
  input  wire logic              sys_clk,
  input  wire logic              resetn,
  input  wire logic              iface_select_strap_i,
  output var  logic              iface_select_strap_o,
  output var  logic              iface_select_strap_oe,
  input  wire logic              host_serial_data_pin_i,
  output var  logic              host_serial_data_pin_o,
  output var  logic              host_serial_data_pin_oe,
  input  wire logic              host_serial_clock_pin_i,
  output var  logic              host_serial_clock_pin_o,
  output var  logic              host_serial_clock_pin_oe,
  input  wire logic              slave_addr_select_i,
  output var  logic              report_pending_irq_n_o,
  output var  logic              report_pending_irq_n_oe,
  input  wire logic [GPIO_N-1:0] gpio_pin_i,
  output var  logic [GPIO_N-1:0] gpio_pin_o,
  output var  logic [GPIO_N-1:0] gpio_pin_oe,
  input  wire logic              report_post,
  input  wire logic              report_consume,
  output var  logic [CNT_W-1:0]  report_count,
  input  wire logic [GPIO_N-1:0] gpio_dir_cfg,
  input  wire logic [GPIO_N-1:0] gpio_out_cfg,
  input  wire logic              hsync_en_cfg,
  input  wire logic              ext_sync_en_cfg,
  output var  logic [GPIO_N-1:0] gpio_in_val,
  output var  logic              hsync_in,
  output var  logic              external_sync_in,
  output var  logic              mode_spi,
  output var  logic              mode_valid,
  output var  logic              i2c_sda_in,
  output var  logic              i2c_scl_in,
  output var  logic              i2c_addr_sel,
  input  wire logic              i2c_sda_drive_low,
  input  wire logic              i2c_scl_drive_low,
  output var  logic              spi_sck,
  output var  logic              spi_select_n,
  output var  logic              spi_mosi,
  input  wire logic              spi_miso
);

  // True when a general purpose pin is claimed as a sync input
  function automatic logic sync_claimed(input int idx, input logic h_en, input logic e_en);
    sync_claimed = (idx == `HPM_HSYNC_PIN && h_en) || (idx == `HPM_ESYNC_PIN && e_en);
  endfunction

  // Synchronisers for the shared host pins
  hpm_host_pins_t pins_s1_r;
  hpm_host_pins_t pins_s2_r;

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      pins_s1_r <= '0;
      pins_s2_r <= '0;
    end else begin
      pins_s1_r <= {iface_select_strap_i, host_serial_data_pin_i,
                    host_serial_clock_pin_i, slave_addr_select_i};
      pins_s2_r <= pins_s1_r;
    end
  end

  // Strap capture: wait for the synchroniser to hold post-reset levels, then latch once
  hpm_state_t st_r;
  hpm_state_t st_nxt;
  logic [1:0] settle_r;
  logic [1:0] settle_nxt;
  hpm_mode_t  mode_r;
  hpm_mode_t  mode_nxt;
  logic       valid_r;
  logic       valid_nxt;

  always_comb begin
    st_nxt     = st_r;
    settle_nxt = settle_r;
    mode_nxt   = mode_r;
    valid_nxt  = valid_r;
    case (st_r)
      HPM_ST_SETTLE: begin
        settle_nxt = settle_r + 2'h1;
        if (settle_r == `HPM_STRAP_SETTLE) begin
          mode_nxt  = hpm_mode_t'(pins_s2_r.strap); // [RULE_04]
          valid_nxt = 1'h1;
          st_nxt    = HPM_ST_RUN;
        end
      end
      HPM_ST_RUN: begin
        st_nxt = HPM_ST_RUN; // Only reset leaves this state [RULE_13]
      end
      default: begin
        st_nxt = HPM_ST_SETTLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      st_r     <= HPM_ST_SETTLE;
      settle_r <= 2'h0;
      mode_r   <= HPM_MODE_I2C;
      valid_r  <= 1'h0;
    end else begin
      st_r     <= st_nxt;
      settle_r <= settle_nxt;
      mode_r   <= mode_nxt;
      valid_r  <= valid_nxt;
    end
  end

  // Pending report count and open-drain interrupt
  logic [CNT_W-1:0] count_r;
  logic [CNT_W-1:0] count_nxt;
  logic             irq_oe_r;
  logic             irq_oe_nxt;

  always_comb begin
    count_nxt = count_r;
    // A post in the same cycle as a read leaves the count unchanged
    if (report_post && !report_consume && count_r != {CNT_W{1'b1}}) begin
      count_nxt = count_r + CNT_W'(1);
    end else if (report_consume && !report_post && count_r != '0) begin
      count_nxt = count_r - CNT_W'(1); // [RULE_02]
    end
    irq_oe_nxt = (count_nxt != '0); // [RULE_01] [RULE_02]
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      count_r  <= '0;
      irq_oe_r <= `HPM_RST_IRQ_OE;
    end else begin
      count_r  <= count_nxt;
      irq_oe_r <= irq_oe_nxt;
    end
  end

  assign report_count            = count_r;
  assign report_pending_irq_n_oe = irq_oe_r;

  always_ff @(posedge sys_clk) begin
    report_pending_irq_n_o <= `HPM_OD_LOW;
  end

  // Host pin roles; everything stays released until the mode is latched
  logic spi_on;
  logic i2c_on;
  logic strap_oe_nxt;
  logic strap_o_nxt;
  logic sda_oe_nxt;
  logic scl_oe_nxt;
  logic strap_oe_r;
  logic strap_o_r;
  logic sda_oe_r;
  logic scl_oe_r;
  logic sck_r;
  logic sel_n_r;
  logic mosi_r;
  logic sda_in_r;
  logic scl_in_r;
  logic addr_r;

  always_comb begin
    spi_on       = valid_r && (mode_r == HPM_MODE_SPI);
    i2c_on       = valid_r && (mode_r == HPM_MODE_I2C);
    strap_oe_nxt = spi_on; // [RULE_05]
    strap_o_nxt  = spi_on ? spi_miso : `HPM_RST_PIN_OUT; // [RULE_05]
    sda_oe_nxt   = i2c_on && i2c_sda_drive_low; // [RULE_09]
    scl_oe_nxt   = i2c_on && i2c_scl_drive_low; // [RULE_09]
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      strap_oe_r <= `HPM_RST_PIN_OE;
      strap_o_r  <= `HPM_RST_PIN_OUT;
      sda_oe_r   <= `HPM_RST_PIN_OE;
      scl_oe_r   <= `HPM_RST_PIN_OE;
      sck_r      <= 1'h0;
      sel_n_r    <= 1'h1;
      mosi_r     <= 1'h0;
      sda_in_r   <= 1'h1;
      scl_in_r   <= 1'h1;
      addr_r     <= 1'h0;
    end else begin
      strap_oe_r <= strap_oe_nxt;
      strap_o_r  <= strap_o_nxt;
      sda_oe_r   <= sda_oe_nxt;
      scl_oe_r   <= scl_oe_nxt;
      sck_r      <= spi_on ? pins_s2_r.sda : 1'h0; // [RULE_06]
      sel_n_r    <= spi_on ? pins_s2_r.scl : 1'h1; // [RULE_07]
      mosi_r     <= spi_on ? pins_s2_r.addr : 1'h0; // [RULE_08]
      sda_in_r   <= i2c_on ? pins_s2_r.sda : 1'h1; // [RULE_09]
      scl_in_r   <= i2c_on ? pins_s2_r.scl : 1'h1; // [RULE_09]
      addr_r     <= i2c_on ? pins_s2_r.addr : 1'h0; // [RULE_10]
    end
  end

  assign iface_select_strap_oe    = strap_oe_r;
  assign iface_select_strap_o     = strap_o_r;
  assign host_serial_data_pin_oe  = sda_oe_r;
  assign host_serial_clock_pin_oe = scl_oe_r;
  assign spi_sck                  = sck_r;
  assign spi_select_n             = sel_n_r;
  assign spi_mosi                 = mosi_r;
  assign i2c_sda_in               = sda_in_r;
  assign i2c_scl_in               = scl_in_r;
  assign i2c_addr_sel             = addr_r;
  assign mode_spi                 = (mode_r == HPM_MODE_SPI);
  assign mode_valid               = valid_r;

  always_ff @(posedge sys_clk) begin
    host_serial_data_pin_o  <= `HPM_OD_LOW;
    host_serial_clock_pin_o <= `HPM_OD_LOW;
  end

  // General purpose pins; a pin claimed for sync is forced to input
  logic [GPIO_N-1:0] gpio_s1_r;
  logic [GPIO_N-1:0] gpio_s2_r;

  for (genvar g = 0; g < GPIO_N; g++) begin : g_gpio
    logic oe_nxt;
    logic oe_r;
    logic o_r;
    logic in_r;
    always_comb begin
      // Direction from config unless the pin is claimed for sync [RULE_11] [RULE_12]
      oe_nxt = gpio_dir_cfg[g] && !sync_claimed(g, hsync_en_cfg, ext_sync_en_cfg);
    end
    always_ff @(posedge sys_clk) begin
      if (!resetn) begin
        gpio_s1_r[g] <= 1'h1;
        gpio_s2_r[g] <= 1'h1;
        oe_r         <= `HPM_RST_PIN_OE;
        o_r          <= `HPM_RST_PIN_OUT;
        in_r         <= 1'h1;
      end else begin
        gpio_s1_r[g] <= gpio_pin_i[g];
        gpio_s2_r[g] <= gpio_s1_r[g];
        oe_r         <= oe_nxt;
        o_r          <= gpio_out_cfg[g];
        in_r         <= gpio_s2_r[g];
      end
    end
    assign gpio_pin_oe[g] = oe_r;
    assign gpio_pin_o[g]  = o_r;
    assign gpio_in_val[g] = in_r;
  end

  logic hsync_r;
  logic esync_r;

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      hsync_r <= 1'h0;
      esync_r <= 1'h0;
    end else begin
      hsync_r <= hsync_en_cfg && gpio_s2_r[`HPM_HSYNC_PIN]; // [RULE_12]
      esync_r <= ext_sync_en_cfg && gpio_s2_r[`HPM_ESYNC_PIN]; // [RULE_12]
    end
  end

  assign hsync_in         = hsync_r;
  assign external_sync_in = esync_r;

  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  sequence s_last_read;
    count_r == CNT_W'(1) && report_consume && !report_post;
  endsequence

  a_irq_pending: assert property (count_r != '0 |-> irq_oe_r) // [RULE_01]
    else $error("interrupt not asserted while reports pending");
  a_irq_release: assert property (s_last_read |=> !irq_oe_r && count_r == '0) // [RULE_02]
    else $error("interrupt not released after last read");
  a_read_consume: assert property (count_r > CNT_W'(1) && report_consume && !report_post
    |=> count_r == $past(count_r) - CNT_W'(1)) // [RULE_02]
    else $error("read did not consume one report");
  a_strap_latch: assert property ($rose(valid_r) // [RULE_04]
    |-> mode_r == hpm_mode_t'($past(pins_s2_r.strap)))
    else $error("mode differs from sampled strap");
  a_strap_time: assert property ($rose(resetn) ##1 resetn [*4] |-> valid_r) // [RULE_04]
    else $error("strap not captured in time");
  a_miso_drive: assert property (valid_r && mode_r == HPM_MODE_SPI
    |=> iface_select_strap_oe && iface_select_strap_o == $past(spi_miso)) // [RULE_05]
    else $error("miso not driven in spi mode");
  a_sck_map: assert property (valid_r && mode_r == HPM_MODE_SPI
    |=> spi_sck == $past(pins_s2_r.sda)) // [RULE_06]
    else $error("sck not routed");
  a_select_map: assert property (valid_r && mode_r == HPM_MODE_SPI
    |=> spi_select_n == $past(pins_s2_r.scl)) // [RULE_07]
    else $error("select not routed");
  a_mosi_map: assert property (valid_r && mode_r == HPM_MODE_SPI
    |=> spi_mosi == $past(pins_s2_r.addr)) // [RULE_08]
    else $error("mosi not routed");
  a_i2c_lines: assert property (valid_r && mode_r == HPM_MODE_I2C
    |=> host_serial_data_pin_oe == $past(i2c_sda_drive_low) && !iface_select_strap_oe) // [RULE_09]
    else $error("i2c lines misrouted");
  a_addr_sel: assert property (valid_r && mode_r == HPM_MODE_I2C
    |=> i2c_addr_sel == $past(pins_s2_r.addr)) // [RULE_10]
    else $error("address select not routed");
  a_gpio_drive: assert property (gpio_dir_cfg[0] |=> gpio_pin_oe[0]) // [RULE_11]
    else $error("gpio not driven");
  a_hsync_pin: assert property (hsync_en_cfg |=> !gpio_pin_oe[`HPM_HSYNC_PIN]) // [RULE_12]
    else $error("sync pin driven");
  a_mode_hold: assert property (valid_r |=> $stable(mode_r) && valid_r) // [RULE_13]
    else $error("mode changed after latch");

endmodule

`default_nettype wire

/* File: hw/hpm_pin_mux_map.svh */
// Purpose: Constants for the host port mode and report interrupt pin logic
// Assumes: Included by its bare name from design files
// Notes:   Definitions only
`ifndef HPM_PIN_MUX_MAP_SVH
`define HPM_PIN_MUX_MAP_SVH

// Number of general purpose pins and the pins that can carry display sync
`define HPM_GPIO_COUNT      5
`define HPM_HSYNC_PIN       1
`define HPM_ESYNC_PIN       2
// Cycles after reset release before the strap is captured (synchroniser settling)
`define HPM_STRAP_SETTLE    2'h3
// Reset values
`define HPM_RST_PIN_OE      1'h0
`define HPM_RST_PIN_OUT     1'h0
`define HPM_RST_IRQ_OE      1'h0
// Open-drain pins only ever pull low
`define HPM_OD_LOW          1'h0

`endif

/* File: hw/hpm_pkg.sv */
// Purpose: Types for the host port mode and report interrupt pin logic
// Assumes: Nothing beyond SystemVerilog packages
// Notes:   Constants live in hpm_pin_mux_map.svh
`default_nettype none

package hpm_pkg;

  // Host interface mode chosen by the strap
  typedef enum logic {
    HPM_MODE_I2C = 1'h0,
    HPM_MODE_SPI = 1'h1
  } hpm_mode_t;

  // Strap capture sequencer, one-hot
  typedef enum logic [1:0] {
    HPM_ST_SETTLE = 2'h1,
    HPM_ST_RUN    = 2'h2
  } hpm_state_t;

  // Levels of the four shared host pins, travelling together
  typedef struct packed {
    logic strap;
    logic sda;
    logic scl;
    logic addr;
  } hpm_host_pins_t;

endpackage

`default_nettype wire

/* File: verification/hpm_host_model.sv */
// Purpose: Host side of the shared pins: pull-ups, line resolution, report servicing
// Assumes: Device pins come split into input, output and output enable
// Notes:   SCK toggles every 200 ns inside SPI frames only
`default_nettype none
module hpm_host_model
  import hpm_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       strap_oe,
  input  wire logic       strap_o,
  input  wire logic       sda_oe,
  input  wire logic       scl_oe,
  input  wire logic       irq_oe,
  input  wire logic [4:0] gpio_oe,
  input  wire logic [4:0] gpio_o,
  input  wire logic       strap_lvl,
  input  wire logic       pull_sda,
  input  wire logic       pull_scl,
  input  wire logic       addr_lvl,
  input  wire logic [4:0] gdrv,
  input  wire logic [4:0] gdrv_en,
  input  wire logic       frame,
  input  wire logic       svc,
  output var  hpm_host_pins_t pins,
  output var  logic       irq_pin,
  output var  logic [4:0] gpio_pin,
  output var  logic       consume_req
);
  timeunit 1ns;
  timeprecision 100ps;
  logic sck_r = 1'b0;
  always #200 sck_r = frame ? ~sck_r : 1'b0;
  // Device drive wins over the strap resistor
  assign pins = '{strap: strap_oe ? strap_o : strap_lvl,
                  sda:   frame ? sck_r : ~(sda_oe | pull_sda),
                  scl:   ~(scl_oe | pull_scl),
                  addr:  addr_lvl};
  assign irq_pin    = ~irq_oe;
  assign gpio_pin   = gpio_oe & gpio_o | ~gpio_oe & (~gdrv_en | gdrv);
  // Level sensed service: keep reading while the line is low
  initial consume_req = 1'b0;
  always @(negedge sys_clk) consume_req <= svc & ~irq_pin;
endmodule
`default_nettype wire

/* File: verification/tb.sv */
// Purpose: Self-checking bench for the host pin mux and report interrupt
// Assumes: 20 MHz clock, stimulus changed at the falling edge
// Notes:   Pin to core paths take three edges
`default_nettype none
module tb
  import hpm_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic sys_clk = 1'b0, resetn = 1'b0;
  logic strap_o, strap_oe, sda_oe, scl_oe, irq_oe, irq_pin, consume_req, post = 1'b0;
  logic tb_consume = 1'b0, hs_en = 1'b0, ex_en = 1'b0, hs, ex, mode_spi, mode_valid;
  logic i2c_sda_in, i2c_scl_in, i2c_addr_sel, sda_dl = 1'b0, scl_dl = 1'b0;
  logic spi_sck, spi_select_n, spi_mosi, spi_miso = 1'b0;
  logic strap_lvl = 1'b0, pull_sda = 1'b0, pull_scl = 1'b0, addr_lvl = 1'b0;
  logic frame = 1'b0, svc = 1'b0, irq_o, sda_o, scl_o;
  logic [4:0] gpio_o, gpio_oe, gpio_pin, gin, dir = 5'h00, outc = 5'h00;
  logic [4:0] gdrv = 5'h00, gdrv_en = 5'h00;
  logic [7:0] count;
  hpm_host_pins_t pins;
  int fails = 0;
  int tests_run = 0;
  always #25 sys_clk = ~sys_clk;
  hpm_pin_mux u_hpm_pin_mux (.sys_clk(sys_clk), .resetn(resetn),
    .iface_select_strap_i(pins.strap), .iface_select_strap_o(strap_o),
    .iface_select_strap_oe(strap_oe), .host_serial_data_pin_i(pins.sda),
    .host_serial_data_pin_o(sda_o), .host_serial_data_pin_oe(sda_oe),
    .host_serial_clock_pin_i(pins.scl), .host_serial_clock_pin_o(scl_o),
    .host_serial_clock_pin_oe(scl_oe), .slave_addr_select_i(pins.addr),
    .report_pending_irq_n_o(irq_o), .report_pending_irq_n_oe(irq_oe), .gpio_pin_i(gpio_pin),
    .gpio_pin_o(gpio_o), .gpio_pin_oe(gpio_oe), .report_post(post),
    .report_consume(tb_consume | consume_req), .report_count(count), .gpio_dir_cfg(dir),
    .gpio_out_cfg(outc), .hsync_en_cfg(hs_en), .ext_sync_en_cfg(ex_en), .gpio_in_val(gin),
    .hsync_in(hs), .external_sync_in(ex), .mode_spi(mode_spi), .mode_valid(mode_valid),
    .i2c_sda_in(i2c_sda_in), .i2c_scl_in(i2c_scl_in), .i2c_addr_sel(i2c_addr_sel),
    .i2c_sda_drive_low(sda_dl), .i2c_scl_drive_low(scl_dl), .spi_sck(spi_sck),
    .spi_select_n(spi_select_n), .spi_mosi(spi_mosi), .spi_miso(spi_miso));
  hpm_host_model u_hpm_host_model (.sys_clk(sys_clk), .strap_oe(strap_oe),
    .strap_o(strap_o), .sda_oe(sda_oe), .scl_oe(scl_oe), .irq_oe(irq_oe),
    .gpio_oe(gpio_oe), .gpio_o(gpio_o), .strap_lvl(strap_lvl), .pull_sda(pull_sda),
    .pull_scl(pull_scl), .addr_lvl(addr_lvl), .gdrv(gdrv), .gdrv_en(gdrv_en),
    .frame(frame), .svc(svc), .pins(pins), .irq_pin(irq_pin), .gpio_pin(gpio_pin),
    .consume_req(consume_req));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  task automatic do_reset(input logic strap);
    int i;
    cyc(1);
    strap_lvl = strap;
    resetn = 1'b0;
    cyc(16);
    resetn = 1'b1;
    for (i = 0; i < 20 && mode_valid !== 1'b1; i++) cyc(1);
    cyc(2);
  endtask
  task automatic t_i2c;
    do_reset(1'b0);
    chk(8'({mode_spi, strap_oe}), 8'h00);
    pull_sda = 1'b1;
    cyc(4);
    chk(8'({i2c_sda_in, i2c_scl_in}), 8'h01);
    pull_sda = 1'b0;
    pull_scl = 1'b1;
    cyc(4);
    chk(8'({i2c_sda_in, i2c_scl_in}), 8'h02);
    pull_scl = 1'b0;
    sda_dl = 1'b1;
    cyc(2);
    chk(8'({sda_oe, scl_oe}), 8'h02);
    sda_dl = 1'b0;
    scl_dl = 1'b1;
    cyc(2);
    chk(8'({sda_oe, scl_oe}), 8'h01);
    scl_dl = 1'b0;
    for (int a = 1; a >= 0; a--) begin
      addr_lvl = a[0];
      cyc(4);
      chk(8'(i2c_addr_sel), 8'(a));
    end
    chk(8'({spi_sck, spi_select_n, spi_mosi}), 8'h02);
    strap_lvl = 1'b1;
    cyc(6);
    chk(8'({mode_spi, strap_oe}), 8'h00);
  endtask
  task automatic t_rep;
    post = 1'b1;
    cyc(3);
    chk(count, 8'h03);
    chk(8'(irq_pin), 8'h00);
    chk(8'({irq_o, sda_o, scl_o}), 8'h00);
    tb_consume = 1'b1;
    cyc(1);
    post = 1'b0;
    tb_consume = 1'b0;
    chk(count, 8'h03);
    svc = 1'b1;
    for (int i = 0; i < 10 && irq_pin !== 1'b1; i++) cyc(1);
    svc = 1'b0;
    cyc(1);
    chk(count, 8'h00);
    chk(8'(irq_pin), 8'h01);
    tb_consume = 1'b1;
    cyc(1);
    tb_consume = 1'b0;
    post = 1'b1;
    cyc(1);
    post = 1'b0;
    chk(8'({count[3:0], irq_pin}), 8'h02);
  endtask
  task automatic t_gpio;
    dir = 5'h1F;
    outc = 5'h15;
    cyc(2);
    chk(8'(gpio_pin), 8'h15);
    dir = 5'h00;
    gdrv_en = 5'h0F;
    gdrv = 5'h0A;
    cyc(4);
    chk(8'(gin), 8'h1A);
    dir = 5'h06;
    outc = 5'h00;
    gdrv_en = 5'h06;
    gdrv = 5'h06;
    hs_en = 1'b1;
    ex_en = 1'b1;
    cyc(4);
    chk(8'({gpio_oe, hs, ex}), 8'h03);
    gdrv = 5'h04;
    cyc(4);
    chk(8'({hs, ex}), 8'h01);
    hs_en = 1'b0;
    ex_en = 1'b0;
    gdrv = 5'h06;
    cyc(4);
    chk(8'({gpio_oe, hs, ex}), 8'h18);
  endtask
  task automatic t_spi;
    do_reset(1'b1);
    chk(8'({mode_spi, strap_oe}), 8'h03);
    strap_lvl = 1'b0;
    for (int k = 0; k < 2; k++) begin
      spi_miso = k[0];
      cyc(2);
      chk(8'(pins.strap), 8'(k));
    end
    sda_dl = 1'b1;
    pull_scl = 1'b1;
    frame = 1'b1;
    for (int k = 0; k < 4; k++) begin
      @(negedge sys_clk);
      addr_lvl = k[0];
      @(u_hpm_host_model.sck_r);
      repeat (3) @(posedge sys_clk);
      #1;
      chk(8'({spi_sck, spi_select_n, spi_mosi}),
          8'({pins.sda, 1'b0, k[0]}));
    end
    chk(8'({sda_oe, i2c_sda_in, i2c_scl_in}), 8'h03);
    @(negedge sys_clk);
    sda_dl = 1'b0;
    frame = 1'b0;
    pull_scl = 1'b0;
    cyc(4);
    chk(8'(spi_select_n), 8'h01);
  endtask
  task automatic report_and_stop;
    if (fails == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    #1000000;
    fails++;
    report_and_stop();
  end
  initial begin
    t_i2c();
    t_rep();
    t_gpio();
    t_spi();
    report_and_stop();
  end
endmodule
`default_nettype wire
